// ===== rtl/ctr_result_regs.sv
// capacitive touch result register bank with mode controls
// What this block does
// - fourth point coord read-only, X high, reset 80008000
// - fifth point Y, 16-bit read-only, reset 8000
// - tags in bits 7..0, upper zero, read-only
// - tags update once per scanned-out frame
// - tags 1..255 valid, zero no touch, reset zero
// - first tag works in both detection modes
// - second tag only in extended mode
// - third tag only in extended mode
// - extended-only registers meaningful only in extended mode
// - detect bit: 0 extended, 1 compatibility, reset 1
// - sampling 00 halts engine, 11 enables sampling
// - up to five points extended, compatibility after reset
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module ctr_result_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // touch engine side, same clock
    input wire logic coordStrobe,
    input wire logic [15:0] fourthX,
    input wire logic [15:0] fourthY,
    input wire logic [15:0] fifthX,
    input wire logic [15:0] fifthY,
    input wire logic [15:0] rawX,
    input wire logic [15:0] rawY,
    input wire logic frameDone,
    input wire logic [ctr_pkg::NUM_TAGS-1:0][ctr_pkg::TAG_WIDTH-1:0] tagIn,
    output logic compatMode,
    output logic engineRun
);
    import ctr_pkg::*;

    // offset match, shared by read and write decode
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction

    ////////////////////////////////////////////////////////////
    // bus front end
    ctr_reg_if regBus ();

    ctr_ahb_port u_port (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .regBus(regBus.bus)
    );

    ////////////////////////////////////////////////////////////
    // state
    logic [1:0] sampleMode; // sampling mode field
    logic [31:0] fourthCoord; // fourth point X:Y
    logic [15:0] fifthXReg; // fifth point X
    logic [15:0] fifthYReg; // fifth point Y
    logic [31:0] rawCoord; // uncalibrated X:Y
    logic [NUM_TAGS-1:0][TAG_WIDTH-1:0] tagReg; // tag results

    ////////////////////////////////////////////////////////////
    // write decode
    wire wrSample = regBus.wrEn && hit(regBus.wrAddr, OFF_SAMPLE_MODE);
    wire wrDetect = regBus.wrEn && hit(regBus.wrAddr, OFF_DETECT_MODE);
    // undefined sampling codes leave the engine halted, safest choice
    wire [1:0] next_sampleMode = wrSample ? regBus.wrData[1:0] : sampleMode;
    wire next_compatMode = wrDetect ? regBus.wrData[0] : compatMode;
    wire next_engineRun = (next_sampleMode == SAMPLE_ON);
    // coordinates are taken only while the engine samples
    wire takeCoord = coordStrobe && engineRun;
    wire takeFrame = frameDone && engineRun;
    wire inExtended = (compatMode == DETECT_EXTENDED);

    ////////////////////////////////////////////////////////////
    // mode controls; reset lands in compatibility, sampling on
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sampleMode <= RST_SAMPLE_MODE;
            compatMode <= RST_DETECT_MODE;
            engineRun <= 1'b1;
        end else begin
            sampleMode <= next_sampleMode;
            compatMode <= next_compatMode;
            engineRun <= next_engineRun;
        end
    end

    ////////////////////////////////////////////////////////////
    // raw coordinate, valid in either mode
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rawCoord <= RST_RAW_COORD;
        end else if (takeCoord) begin
            rawCoord <= {rawX, rawY};
        end
    end

    ////////////////////////////////////////////////////////////
    // extended-only coordinates; compatibility forces reset values
    // so software never reads a stale multi-touch position
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fourthCoord <= RST_POINT_COORD;
            fifthXReg <= RST_POINT_AXIS;
            fifthYReg <= RST_POINT_AXIS;
        end else if (!inExtended) begin
            fourthCoord <= RST_POINT_COORD;
            fifthXReg <= RST_POINT_AXIS;
            fifthYReg <= RST_POINT_AXIS;
        end else if (takeCoord) begin
            fourthCoord <= {fourthX, fourthY};
            fifthXReg <= fifthX;
            fifthYReg <= fifthY;
        end
    end

    ////////////////////////////////////////////////////////////
    // tag holders; first works in both modes, others extended only
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TAGS; gi++) begin : g_tag
            ctr_tag_latch #(
                .WIDTH(TAG_WIDTH)
            ) u_tag (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .load(takeFrame),
                .clear((gi != 0) && !inExtended),
                .din(tagIn[gi]),
                .q(tagReg[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////
    // read selection; unmapped offsets read zero
    wire [11:0] ra = regBus.rdAddr;
    // named read selects, shared by the mux and the checks
    wire selSample = hit(ra, OFF_SAMPLE_MODE);
    wire selDetect = hit(ra, OFF_DETECT_MODE);
    wire selRaw = hit(ra, OFF_RAW_COORD);
    wire selFifthY = hit(ra, OFF_FIFTH_Y);
    wire selTag0 = hit(ra, OFF_FIRST_TAG);
    wire selTag1 = hit(ra, OFF_SECOND_TAG);
    wire selTag2 = hit(ra, OFF_THIRD_TAG);
    wire selFifthX = hit(ra, OFF_FIFTH_X);
    wire selFourth = hit(ra, OFF_FOURTH_COORD);
    wire [31:0] tagWord0 = {24'h000000, tagReg[0]};
    wire [31:0] tagWord1 = {24'h000000, tagReg[1]};
    wire [31:0] tagWord2 = {24'h000000, tagReg[2]};
    assign regBus.rdData =
        selSample ? {30'h0, sampleMode} :
        selDetect ? {31'h0, compatMode} :
        selRaw ? rawCoord :
        selFifthY ? {16'h0000, fifthYReg} :
        selTag0 ? tagWord0 :
        selTag1 ? tagWord1 :
        selTag2 ? tagWord2 :
        selFifthX ? {16'h0000, fifthXReg} :
        selFourth ? fourthCoord : 32'h00000000;

    ////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // fourth point read returns the word held at the address-phase edge
    chk_fourth_read: assert property (
        regBus.rdEn && selFourth |=> hrdata == $past(fourthCoord))
        else $error("fourth point read data wrong");

    // fourth point loads X high, Y low from the engine
    chk_fourth_load: assert property (
        inExtended && takeCoord |=> fourthCoord == {$past(fourthX), $past(fourthY)})
        else $error("fourth point not loaded");

    // fifth X pinned at its reset value outside extended mode
    chk_fifth_x_compat: assert property (
        !inExtended |=> fifthXReg == RST_POINT_AXIS)
        else $error("fifth X not at reset value in compatibility");

    // fifth X loads in extended mode
    chk_fifth_x_load: assert property (
        inExtended && takeCoord |=> fifthXReg == $past(fifthX))
        else $error("fifth X not loaded");

    // fifth X reads back as a zero-extended half-word
    chk_fifth_x_read: assert property (
        regBus.rdEn && selFifthX |=> hrdata == {16'h0000, $past(fifthXReg)})
        else $error("fifth X read data wrong");

    // fifth Y loads in extended mode
    chk_fifth_y_load: assert property (
        inExtended && takeCoord && !wrDetect |=> fifthYReg == $past(fifthY))
        else $error("fifth Y not loaded");

    // fifth Y pinned at its reset value outside extended mode
    chk_fifth_y_compat: assert property (
        !inExtended |=> fifthYReg == RST_POINT_AXIS)
        else $error("fifth Y not at reset value in compatibility");

    // raw coordinate follows every taken strobe, either mode
    chk_raw_load: assert property (
        takeCoord |=> rawCoord == {$past(rawX), $past(rawY)})
        else $error("raw coordinate not loaded");

    // raw coordinate read returns the held word
    chk_raw_read: assert property (
        regBus.rdEn && selRaw |=> hrdata == $past(rawCoord))
        else $error("raw coordinate read data wrong");

    // reserved second tag bits always read zero
    chk_tag_upper_zero: assert property (
        regBus.rdEn && hit(ra, OFF_SECOND_TAG) |=> hrdata[31:8] == 24'h000000)
        else $error("tag upper bits not zero");

    // first tag read returns the held tag in the low byte
    chk_tag0_read: assert property (
        regBus.rdEn && selTag0 |=> hrdata == {24'h000000, $past(tagReg[0])})
        else $error("first tag read data wrong");

    // first tag moves only at a taken frame end
    chk_tag_frame_only: assert property (
        !takeFrame && compatMode == $past(compatMode) |=> $stable(tagReg[0]))
        else $error("first tag changed outside frame end");

    // a halted engine sees no frame end
    chk_tag_hold_halt: assert property (
        !engineRun |=> $stable(tagReg[0]))
        else $error("first tag changed while halted");

    // first tag loads in either mode
    chk_first_tag_load: assert property (
        takeFrame |=> tagReg[0] == $past(tagIn[0]))
        else $error("first tag not loaded at frame end");

    // second tag cleared outside extended mode
    chk_second_tag_mode: assert property (
        !inExtended |=> tagReg[1] == RST_TAG)
        else $error("second tag nonzero in compatibility");

    // second tag loads at frame end in extended mode
    chk_second_tag_load: assert property (
        inExtended && takeFrame |=> tagReg[1] == $past(tagIn[1]))
        else $error("second tag not loaded at frame end");

    // third tag and fourth point held after two compatibility cycles
    chk_third_tag_mode: assert property (
        !inExtended ##1 !inExtended |-> tagReg[2] == RST_TAG && fourthCoord == RST_POINT_COORD)
        else $error("extended results not held in compatibility");

    // third tag loads at frame end in extended mode
    chk_third_tag_load: assert property (
        inExtended && takeFrame |=> tagReg[2] == $past(tagIn[2]))
        else $error("third tag not loaded at frame end");

    // third tag read returns the held tag in the low byte
    chk_tag2_read: assert property (
        regBus.rdEn && selTag2 |=> hrdata == {24'h000000, $past(tagReg[2])})
        else $error("third tag read data wrong");

    // fourth point pinned at its reset value outside extended mode
    chk_fourth_compat: assert property (
        !inExtended |=> fourthCoord == RST_POINT_COORD)
        else $error("fourth point not at reset value in compatibility");

    // detect bit takes the written value
    chk_detect_write: assert property (
        wrDetect |=> compatMode == $past(regBus.wrData[0]))
        else $error("detect mode write not taken");

    // detect bit reads back in bit 0
    chk_detect_read: assert property (
        regBus.rdEn && selDetect |=> hrdata == {31'h0, $past(compatMode)})
        else $error("detect mode read data wrong");

    // sampling off halts the engine and freezes coordinates
    chk_sample_halt: assert property (
        wrSample && regBus.wrData[1:0] == SAMPLE_OFF ##1 !wrSample |=> !engineRun && $stable(rawCoord))
        else $error("engine not halted by sampling off");

    // sampling field and run flag follow every write
    chk_sample_write: assert property (
        wrSample |=> sampleMode == $past(regBus.wrData[1:0]) && engineRun == ($past(regBus.wrData[1:0]) == SAMPLE_ON))
        else $error("sampling mode write not taken");

    // no coordinate enters while halted
    chk_coord_halt: assert property (
        !engineRun |=> $stable(rawCoord))
        else $error("raw coordinate changed while halted");

    // main scenarios reached
    cov_extended_mode: cover property (wrDetect && regBus.wrData[0] == DETECT_EXTENDED);
    cov_frame_tag: cover property (takeFrame && tagIn[0] != RST_TAG);
    cov_tag_read: cover property (regBus.rdEn && hit(ra, OFF_FIRST_TAG));
    cov_halt: cover property (wrSample && regBus.wrData[1:0] == SAMPLE_OFF);
    cov_extended_frame: cover property (inExtended && takeFrame && tagIn[2] != RST_TAG);
endmodule
`default_nettype wire

// ===== rtl/ctr_pkg.sv
// constants shared by the touch result register bank
`default_nettype none
package ctr_pkg;
    // register byte offsets (12-bit decode window)
    localparam logic [11:0] OFF_SAMPLE_MODE = 12'h104;
    localparam logic [11:0] OFF_DETECT_MODE = 12'h108;
    localparam logic [11:0] OFF_RAW_COORD = 12'h11C;
    localparam logic [11:0] OFF_FIFTH_Y = 12'h120;
    localparam logic [11:0] OFF_FIRST_TAG = 12'h12C;
    localparam logic [11:0] OFF_SECOND_TAG = 12'h134;
    localparam logic [11:0] OFF_THIRD_TAG = 12'h13C;
    localparam logic [11:0] OFF_FIFTH_X = 12'h16C;
    localparam logic [11:0] OFF_FOURTH_COORD = 12'h190;
    // values after reset
    localparam logic [1:0] RST_SAMPLE_MODE = 2'h3;
    localparam logic RST_DETECT_MODE = 1'b1;
    localparam logic [31:0] RST_RAW_COORD = 32'h0FFFFFFF;
    localparam logic [15:0] RST_POINT_AXIS = 16'h8000;
    localparam logic [31:0] RST_POINT_COORD = 32'h80008000;
    localparam logic [7:0] RST_TAG = 8'h00;
    // field layout and encodings
    localparam int TAG_WIDTH = 8;
    localparam int NUM_TAGS = 3;
    localparam logic [1:0] SAMPLE_OFF = 2'h0;
    localparam logic [1:0] SAMPLE_ON = 2'h3;
    localparam logic DETECT_EXTENDED = 1'b0;
    // ahb encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

// ===== rtl/ctr_reg_if.sv
// carrier between the bus port and the register bank
`timescale 1ns/1ns
`default_nettype none
interface ctr_reg_if;
    logic rdEn; // read taken in address phase
    logic [11:0] rdAddr; // read offset
    logic [31:0] rdData; // selected read word
    logic wrEn; // write data phase pulse
    logic [11:0] wrAddr; // write offset
    logic [31:0] wrData; // write word
    modport bus (output rdEn, rdAddr, wrEn, wrAddr, wrData, input rdData);
    modport regs (input rdEn, rdAddr, wrEn, wrAddr, wrData, output rdData);
endinterface
`default_nettype wire

// ===== rtl/ctr_ahb_port.sv
// ahb-lite slave front end, zero wait states
`timescale 1ns/1ns
`default_nettype none
module ctr_ahb_port (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    ctr_reg_if.bus regBus
);
    import ctr_pkg::*;
    ////////////////////////////////////////////////////////////
    // address phase decode; only whole-word transfers are taken
    wire takeReq = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    logic wrPend; // write waiting for its data phase
    logic [11:0] wrAddrQ; // offset held for the data phase
    assign regBus.rdEn = takeReq && !hwrite;
    assign regBus.rdAddr = haddr[11:0];
    assign regBus.wrEn = wrPend;
    assign regBus.wrAddr = wrAddrQ;
    assign regBus.wrData = hwdata;
    ////////////////////////////////////////////////////////////
    // read data is captured in the address phase so it stands in the data phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrPend <= 1'b0;
            wrAddrQ <= 12'h000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= HRESP_OKAY;
        end else begin
            wrPend <= takeReq && hwrite;
            wrAddrQ <= haddr[11:0];
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            if (regBus.rdEn) begin
                hrdata <= regBus.rdData;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/ctr_tag_latch.sv
// one tag result holder, loaded at frame end
`timescale 1ns/1ns
`default_nettype none
module ctr_tag_latch #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic load,
    input wire logic clear,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] q
);
    ////////////////////////////////////////////////////////////
    // clear wins: a point not tracked must not show a stale tag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (clear) begin
            q <= '0;
        end else if (load) begin
            q <= din;
        end
    end
endmodule
`default_nettype wire

// ===== dv/ctr_result_regs_tb.sv
// self-checking bench for the touch result register bank
`timescale 1ns/1ns
`default_nettype none
module ctr_result_regs_tb;
    import ctr_pkg::*;
    logic clk_sys, resetn, hsel, hwrite, hreadyout, hresp; // bus control
    logic [31:0] haddr, hwdata, hrdata; // bus data
    logic [1:0] htrans; // transfer type
    logic [2:0] hsize; // transfer size
    logic coordStrobe, frameDone, compatMode, engineRun; // engine side
    logic [15:0] fourthX, fourthY, fifthX, fifthY, rawX, rawY; // engine coordinates
    logic [NUM_TAGS-1:0][TAG_WIDTH-1:0] tagIn; // engine tags
    int failCount = 0; // mismatches
    int checked = 0; // comparisons

    ctr_result_regs ctr_result_regs_i (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .coordStrobe(coordStrobe),
        .fourthX(fourthX), .fourthY(fourthY), .fifthX(fifthX), .fifthY(fifthY), .rawX(rawX), .rawY(rawY),
        .frameDone(frameDone), .tagIn(tagIn), .compatMode(compatMode), .engineRun(engineRun));

    ////////////////////////////////////////////////////////////////////////
    // clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // single compare for every kind of result, four-state exact
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one whole-word transfer; no wait count assumed, the watchdog cuts a hang
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        r = hrdata;
        chk("response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
        chk("ready", 32'h1, {31'h0, hreadyout});
    endtask

    // read and compare one register
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        chk($sformatf("reg %h", a), exp, r);
    endtask

    // plain write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // engine pulse: coordinates from base b, tags t, t+1, t+2
    task automatic eng(input logic c, input logic f, input logic [15:0] b, input logic [7:0] t);
        @(posedge clk_sys);
        coordStrobe <= c;
        frameDone <= f;
        fourthX <= b;
        fourthY <= b + 16'h1;
        fifthX <= b + 16'h2;
        fifthY <= b + 16'h3;
        rawX <= b + 16'h4;
        rawY <= b + 16'h5;
        tagIn <= {t + 8'h2, t + 8'h1, t};
        @(posedge clk_sys);
        coordStrobe <= 1'b0;
        frameDone <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset values and an unmapped place
    task automatic t_reset();
        chk("compatMode", 32'h1, {31'h0, compatMode});
        chk("engineRun", 32'h1, {31'h0, engineRun});
        rd(OFF_SAMPLE_MODE, 32'h00000003);
        rd(OFF_DETECT_MODE, 32'h00000001);
        rd(OFF_RAW_COORD, 32'h0FFFFFFF);
        rd(OFF_FIFTH_Y, 32'h00008000);
        rd(OFF_FIFTH_X, 32'h00008000);
        rd(OFF_FOURTH_COORD, 32'h80008000);
        rd(OFF_FIRST_TAG, 32'h00000000);
        rd(OFF_SECOND_TAG, 32'h00000000);
        rd(OFF_THIRD_TAG, 32'h00000000);
        wr(12'h200, 32'hFFFFFFFF);
        rd(12'h200, 32'h00000000);
    endtask

    // compatibility mode: extended registers stay at reset
    task automatic t_compat();
        eng(1'b1, 1'b1, 16'h0100, 8'h11);
        wr(OFF_FOURTH_COORD, 32'h12345678);
        wr(OFF_FIRST_TAG, 32'h000000AA);
        rd(OFF_RAW_COORD, 32'h01040105);
        rd(OFF_FOURTH_COORD, 32'h80008000);
        rd(OFF_FIFTH_X, 32'h00008000);
        rd(OFF_FIFTH_Y, 32'h00008000);
        rd(OFF_FIRST_TAG, 32'h00000011);
        rd(OFF_SECOND_TAG, 32'h00000000);
        rd(OFF_THIRD_TAG, 32'h00000000);
    endtask

    // extended mode: all points, tags only at frame end
    task automatic t_extended();
        wr(OFF_DETECT_MODE, 32'h00000000);
        // mode bit settles in the edge that returns the write
        @(negedge clk_sys);
        chk("compatMode", 32'h0, {31'h0, compatMode});
        eng(1'b1, 1'b1, 16'h2000, 8'hFD);
        rd(OFF_FOURTH_COORD, 32'h20002001);
        rd(OFF_FIFTH_X, 32'h00002002);
        rd(OFF_FIFTH_Y, 32'h00002003);
        rd(OFF_FIRST_TAG, 32'h000000FD);
        rd(OFF_SECOND_TAG, 32'h000000FE);
        rd(OFF_THIRD_TAG, 32'h000000FF);
        eng(1'b1, 1'b0, 16'h3000, 8'h01);
        rd(OFF_FOURTH_COORD, 32'h30003001);
        rd(OFF_FIRST_TAG, 32'h000000FD);
        eng(1'b0, 1'b1, 16'h3000, 8'h01);
        rd(OFF_FIRST_TAG, 32'h00000001);
        rd(OFF_THIRD_TAG, 32'h00000003);
    endtask

    // every sampling code; only 11 lets coordinates in
    task automatic t_sampling();
        logic [31:0] raw;
        logic [15:0] b;
        raw = 32'h30043005;
        for (int i = 0; i < 4; i++) begin
            b = {12'h400, i[1:0], 2'b00};
            wr(OFF_SAMPLE_MODE, {30'h0, i[1:0]});
            rd(OFF_SAMPLE_MODE, {30'h0, i[1:0]});
            chk("engineRun", {31'h0, i == 3}, {31'h0, engineRun});
            eng(1'b1, 1'b0, b, 8'h05);
            if (i == 3) begin
                raw = {b + 16'h4, b + 16'h5};
            end
            rd(OFF_RAW_COORD, raw);
        end
    endtask

    // back to compatibility: stale multi-touch results vanish
    task automatic t_back();
        wr(OFF_DETECT_MODE, 32'h00000001);
        // mode bit settles in the edge that returns the write
        @(negedge clk_sys);
        chk("compatMode", 32'h1, {31'h0, compatMode});
        rd(OFF_FOURTH_COORD, 32'h80008000);
        rd(OFF_FIFTH_Y, 32'h00008000);
        rd(OFF_SECOND_TAG, 32'h00000000);
        rd(OFF_FIRST_TAG, 32'h00000001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict, reached from the main sequence or the watchdog
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog, far above the roughly 160 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        failCount++;
        print_verdict();
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h00000000;
        coordStrobe = 1'b0;
        frameDone = 1'b0;
        {fourthX, fourthY, fifthX, fifthY, rawX, rawY} = '0;
        tagIn = '0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_compat();
        t_extended();
        t_sampling();
        t_back();
        print_verdict();
    end
endmodule
`default_nettype wire
